// >>> design/lcdsr_core.sv
// lcdsr_core: serial instruction receiver and decoder with bus slave.
// assumes: AHB-Lite master on mclk_i; host drives the serial link.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module lcdsr_core
	import lcdsr_pkg::*;
#(
	parameter logic [7:0] DEV_ADDR = 8'h5a // arbitrary value
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic [31:0] hrdata_o,
	output logic hresp_o,
	// serial link
	input wire logic shift_clock_i,
	input wire logic chip_enable_i,
	input wire logic serial_data_i,
	input wire logic hard_clear_n_i,
	// decoded settings and ram writes
	output lcdsr_cfg_s cfg_o,
	output lcdsr_ram_s ram_o,
	output logic osc_run_o,
	output logic booster_on_o,
	output logic booster_discharge_o
);
	// ****************************************************************
	// link domain
	// ****************************************************************
	lcdsr_link_s lk;
	lcdsr_link_s next_lk;
	logic fresh;
	logic [8:0] lk_cnt;
	logic [8:0] lk_idx;

	// enable low rearms the count, so either clock park level works
	always_ff @(posedge shift_clock_i or negedge chip_enable_i) begin
		if (!chip_enable_i) begin
			fresh <= 1'b1;
		end else begin
			fresh <= 1'b0;
		end
	end

	assign lk_cnt = fresh ? 9'h000 : lk.cnt;
	assign lk_idx = lk_cnt - ADDR_LEN;

	// store each of the first 280 sampled bits at its position in the frame
	always_comb begin
		next_lk = lk;
		if (chip_enable_i) begin
			if (lk_cnt < ADDR_LEN) begin
				next_lk.addr[lk_cnt[2:0]] = serial_data_i;
			end else if (lk_idx < LEN_BULK16) begin
				next_lk.idata[lk_idx] = serial_data_i;
			end
			if (lk_cnt != CNT_MAX) begin
				next_lk.cnt = lk_cnt + 9'h001;
			end else begin
				next_lk.cnt = lk_cnt;
			end
		end
	end

	// link state; only its count is cleared in effect by fresh at each frame start
	always_ff @(posedge shift_clock_i) begin
		lk <= next_lk;
	end

	// ****************************************************************
	// crossing and frame evaluation
	// ****************************************************************
	lcdsr_core_s st;
	lcdsr_core_s next_st;
	logic ce_s;
	logic hc_s;
	logic fall;
	logic [8:0] len;
	logic [3:0] code;
	logic [7:0] col;
	logic [3:0] row8;
	logic ok8;
	logic ok16;
	logic addr_ok;
	logic take;
	logic [31:0] status_word;

	lcdsr_sync #(
		.W(2)
	) u_sync (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.async_i({chip_enable_i, hard_clear_n_i}),
		.sync_o({ce_s, hc_s})
	);

	// link words are still while enable is low, so read them at the fall
	assign fall = st.ce_d & ~ce_s;
	assign len = lk.cnt - ADDR_LEN;
	assign code = lk.idata[POS_CODE +: 4];
	assign row8 = lk.idata[B8_ROW +: 4];
	assign col = (len == LEN_BULK16) ? lk.idata[B16_COL +: 8]
		: lk.idata[B8_COL +: 8];
	assign addr_ok = (lk.cnt >= ADDR_LEN) && (lk.addr == DEV_ADDR);
	assign ok8 = (col >= COL_MIN) && (col <= B8_COL_MAX)
		&& (row8 == ROW_LOW || row8 == ROW_HIGH);
	assign ok16 = (col >= COL_MIN) && (col <= B16_COL_MAX);
	assign take = hsel_i & htrans_i[1] & hready_i;

	// receiver status only; settings stay unreadable
	always_comb begin
		status_word = 32'h00000000;
		status_word[ST_CNT +: 9] = st.last_cnt;
		status_word[ST_RES +: 2] = st.res;
		status_word[ST_METH] = st.method_seen;
		status_word[ST_FRM +: 8] = st.frames;
	end

	// next state: bus, frame decode, hard clear
	always_comb begin
		next_st = st;
		next_st.ce_d = ce_s;
		next_st.ram.wr = 1'b0;
		next_st.pend_wr = take & hwrite_i;
		if (take) begin
			next_st.pend_ofs = haddr_i[7:0];
		end
		if (take && !hwrite_i) begin
			if (haddr_i[7:0] == OFS_CTRL) begin
				next_st.rdata = {31'h00000000, st.rx_en};
			end else if (haddr_i[7:0] == OFS_STATUS) begin
				next_st.rdata = status_word;
			end else begin
				next_st.rdata = 32'h00000000;
			end
		end
		if (st.pend_wr && st.pend_ofs == OFS_CTRL) begin
			next_st.rx_en = hwdata_i[0];
		end
		if (fall && st.rx_en) begin
			next_st.frames = st.frames + 8'h01;
			next_st.last_cnt = lk.cnt;
			next_st.res = RES_OK;
			if (lk.cnt < ADDR_LEN) begin
				next_st.res = RES_LEN;
			end else if (!addr_ok) begin
				next_st.res = RES_ADDR;
			end else begin
				case (len)
					LEN_METHOD: begin
						next_st.method_seen = 1'b1;
						next_st.cfg.fund_timing_source = lk.idata[POS_OC];
						next_st.cfg.booster_run = lk.idata[POS_DBC];
						next_st.cfg.contrast_adjust_run = lk.idata[POS_CONTRAST_ADJUST_RUN];
						next_st.cfg.bias_generator_run = lk.idata[POS_BIAS_GENERATOR_RUN];
						next_st.cfg.duty = lk.idata[POS_DT +: 4];
						next_st.cfg.drive_mode = lk.idata[POS_DR];
						next_st.cfg.wave_mode = lk.idata[POS_WVC];
						next_st.cfg.common_flip = lk.idata[POS_CDIR];
						next_st.cfg.segment_order_flip = lk.idata[POS_SEGMENT_ORDER_FLIP];
						next_st.cfg.boost_freq = lk.idata[POS_DBF +: 3];
						next_st.cfg.frame_freq = lk.idata[POS_FC +: 4];
					end
					LEN_SHORT: begin
						if (code == CODE_ONOFF) begin
							next_st.cfg.display_on = lk.idata[POS_PNC];
							next_st.cfg.show_mode = lk.idata[POS_SC +: 2];
							next_st.cfg.power_save = lk.idata[POS_BU];
						end else if (code == CODE_LINE) begin
							next_st.cfg.line_addr = lk.idata[POS_LINE +: 4];
						end else if (code == CODE_CONTRAST) begin
							next_st.cfg.contrast = lk.idata[POS_CT +: 6];
						end else begin
							next_st.res = RES_LEN;
						end
					end
					LEN_BULK8: begin
						if (ok8) begin
							next_st.ram.wr = 1'b1;
							next_st.ram.wide = 1'b0;
							next_st.ram.row = row8;
							next_st.ram.page = 4'h0;
							next_st.ram.data = '0;
							next_st.ram.data[119:0] = lk.idata[119:0];
						end else begin
							next_st.res = RES_RANGE;
						end
					end
					LEN_BULK16: begin
						if (ok16) begin
							next_st.ram.wr = 1'b1;
							next_st.ram.wide = 1'b1;
							next_st.ram.row = ROW_LOW;
							next_st.ram.page = lk.idata[B16_PAGE +: 4];
							next_st.ram.data = lk.idata[RAM_BITS-1:0];
						end else begin
							next_st.res = RES_RANGE;
						end
					end
					default: begin
						next_st.res = RES_LEN;
					end
				endcase
			end
			// column to segment, reversed when the flip flag is set
			if (st.cfg.segment_order_flip) begin
				next_st.ram.seg = SEG_LAST - col + 8'h01;
			end else begin
				next_st.ram.seg = col;
			end
		end
		if (!hc_s) begin
			next_st.cfg = CFG_RST;
			next_st.method_seen = 1'b0;
			next_st.ram.wr = 1'b0;
		end
	end

	// register the system state
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st <= '0;
			st.rx_en <= 1'b1;
			st.cfg <= CFG_RST;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = st.rdata;
	assign cfg_o = st.cfg;
	assign ram_o = st.ram;
	// method frame must come first before the oscillator is trusted
	assign osc_run_o = st.method_seen & ~st.cfg.fund_timing_source
		& ~st.cfg.power_save;
	assign booster_discharge_o = ~hc_s
		| (st.cfg.booster_run & st.cfg.power_save);
	assign booster_on_o = st.cfg.booster_run & ~booster_discharge_o;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	len_keep_a: assert property (fall && st.rx_en && hc_s && addr_ok
		&& len != LEN_SHORT && len != LEN_METHOD && len != LEN_BULK8
		&& len != LEN_BULK16 |=> $stable(st.cfg) && !ram_o.wr)
		else $error("bad length frame changed state");
	addr_skip_a: assert property (fall && hc_s && !addr_ok
		|=> $stable(st.cfg) && !ram_o.wr)
		else $error("foreign address frame acted on");
	method_load_a: assert property (fall && st.rx_en && hc_s && addr_ok
		&& len == LEN_METHOD |=> st.method_seen
		&& cfg_o.segment_order_flip == $past(lk.idata[POS_SEGMENT_ORDER_FLIP]))
		else $error("method frame not applied");
	bulk8_range_a: assert property (ram_o.wr && !ram_o.wide
		|-> $past(ok8) && $past(len) == LEN_BULK8)
		else $error("8x15 write outside window");
	bulk16_range_a: assert property (ram_o.wr && ram_o.wide
		|-> $past(ok16) && ram_o.row == ROW_LOW)
		else $error("16x16 write outside window");
	seg_order_a: assert property (ram_o.wr
		|-> ram_o.seg == ($past(st.cfg.segment_order_flip)
		? SEG_LAST - $past(col) + 8'h01 : $past(col)))
		else $error("segment order wrong");
	osc_gate_a: assert property (osc_run_o |-> !cfg_o.power_save)
		else $error("oscillator running in power save");
	discharge_a: assert property (!hc_s
		|-> booster_discharge_o && !booster_on_o ##1 !ram_o.wr)
		else $error("booster not forced to discharge");
	ram_pulse_a: assert property (ram_o.wr |=> !ram_o.wr)
		else $error("ram write longer than one cycle");
	ctrl_read_a: assert property (take && !hwrite_i
		&& haddr_i[7:0] == OFS_CTRL |=> hrdata_o == {31'h0, $past(st.rx_en)})
		else $error("control readback wrong");
endmodule

// >>> design/lcdsr_pkg.sv
// lcdsr_pkg: constants and types of the serial instruction receiver.
// assumes: shared by the receiver core and its testbench.
package lcdsr_pkg;
	// ****************************************************************
	// frame lengths and positions
	// ****************************************************************
	localparam logic [8:0] ADDR_LEN = 9'h008;
	localparam logic [8:0] LEN_SHORT = 9'h010;
	localparam logic [8:0] LEN_METHOD = 9'h020;
	localparam logic [8:0] LEN_BULK8 = 9'h090;
	localparam logic [8:0] LEN_BULK16 = 9'h110;
	localparam logic [8:0] CNT_MAX = 9'h1ff;
	localparam int DATA_BITS = 272;
	localparam int RAM_BITS = 256;
	localparam int POS_OC = 0;
	localparam int POS_DBC = 4;
	localparam int POS_CONTRAST_ADJUST_RUN = 5;
	localparam int POS_BIAS_GENERATOR_RUN = 6;
	localparam int POS_DT = 8;
	localparam int POS_DR = 12;
	localparam int POS_WVC = 13;
	localparam int POS_CDIR = 16;
	localparam int POS_SEGMENT_ORDER_FLIP = 17;
	localparam int POS_DBF = 20;
	localparam int POS_FC = 24;
	localparam int POS_PNC = 0;
	localparam int POS_SC = 4;
	localparam int POS_BU = 7;
	localparam int POS_LINE = 0;
	localparam int POS_CT = 0;
	localparam int POS_CODE = 12;
	localparam int B8_COL = 120;
	localparam int B8_ROW = 128;
	localparam int B16_COL = 256;
	localparam int B16_PAGE = 264;
	// short instruction codes
	localparam logic [3:0] CODE_ONOFF = 4'h1;
	localparam logic [3:0] CODE_LINE = 4'h2;
	localparam logic [3:0] CODE_CONTRAST = 4'h3;
	// bulk write window limits
	localparam logic [7:0] COL_MIN = 8'h01;
	localparam logic [7:0] B8_COL_MAX = 8'hba;
	localparam logic [7:0] B16_COL_MAX = 8'hb9;
	localparam logic [7:0] SEG_LAST = 8'hc8;
	localparam logic [3:0] ROW_LOW = 4'h1;
	localparam logic [3:0] ROW_HIGH = 4'h9;
	// ****************************************************************
	// bus map
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam int ST_CNT = 0;
	localparam int ST_RES = 9;
	localparam int ST_METH = 11;
	localparam int ST_FRM = 12;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		RES_OK = 2'b00,
		RES_ADDR = 2'b01,
		RES_LEN = 2'b10,
		RES_RANGE = 2'b11
	} lcdsr_res_e;
	typedef struct packed {
		logic fund_timing_source;
		logic booster_run;
		logic contrast_adjust_run;
		logic bias_generator_run;
		logic [3:0] duty;
		logic drive_mode;
		logic wave_mode;
		logic common_flip;
		logic segment_order_flip;
		logic [2:0] boost_freq;
		logic [3:0] frame_freq;
		logic display_on;
		logic [1:0] show_mode;
		logic power_save;
		logic [3:0] line_addr;
		logic [5:0] contrast;
	} lcdsr_cfg_s;
	localparam lcdsr_cfg_s CFG_RST = 33'h000000400;
	typedef struct packed {
		logic wr;
		logic wide;
		logic [7:0] seg;
		logic [3:0] row;
		logic [3:0] page;
		logic [RAM_BITS-1:0] data;
	} lcdsr_ram_s;
	typedef struct packed {
		logic [8:0] cnt;
		logic [7:0] addr;
		logic [DATA_BITS-1:0] idata;
	} lcdsr_link_s;
	typedef struct packed {
		logic ce_d;
		logic rx_en;
		logic method_seen;
		logic [8:0] last_cnt;
		lcdsr_res_e res;
		logic [7:0] frames;
		lcdsr_cfg_s cfg;
		lcdsr_ram_s ram;
		logic pend_wr;
		logic [7:0] pend_ofs;
		logic [31:0] rdata;
	} lcdsr_core_s;
endpackage

// >>> design/lcdsr_sync.sv
// lcdsr_sync: two-stage level synchroniser into the system clock.
// assumes: inputs are slow levels from pins.
`timescale 1ns/1ns
module lcdsr_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// levels
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	// ****************************************************************
	// two flops, the first read only by the second
	// ****************************************************************
	logic [1:0][W-1:0] st;
	logic [1:0][W-1:0] next_st;

	// shift the stages
	always_comb begin
		next_st[0] = async_i;
		next_st[1] = st[0];
	end

	// register the stages
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_o = st[1];
endmodule

// >>> dv/lcd_serial_instruction_receiver_tb.sv
// lcd_serial_instruction_receiver_tb: self-checking bench of lcdsr_core.
// assumes: single ahb-lite slave, host model drives the serial link.
`timescale 1ns/1ns
module lcd_serial_instruction_receiver_tb
	import lcdsr_pkg::*;
();
	localparam logic [7:0] DA = 8'h5a; // arbitrary value
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic hclr_n = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd_q;
	logic hready, hresp, sclk, ce, sdat, osc_run, b_on, disch, ms;
	lcdsr_cfg_s cfg;
	lcdsr_cfg_s ec;
	lcdsr_ram_s ram;
	lcdsr_res_e pr;
	logic [8:0] pn;
	logic [287:0] d;
	logic [39:0] exp_q[$];
	logic [43:0] ram_q[$];
	logic [43:0] re;
	event rd_ev;
	int errors = 0;
	int checked = 0;
	int seed = 35;
	// system clock, 20 ns
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	lcdsr_core #(.DEV_ADDR(DA)) dut (
		.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp),
		.shift_clock_i(sclk), .chip_enable_i(ce), .serial_data_i(sdat),
		.hard_clear_n_i(hclr_n), .cfg_o(cfg), .ram_o(ram),
		.osc_run_o(osc_run), .booster_on_o(b_on),
		.booster_discharge_o(disch)
	);
	lcdsr_host_model host (.shift_clock_o(sclk), .chip_enable_o(ce),
		.serial_data_o(sdat));
	// ****************************************************************
	// checking and bus tasks
	// ****************************************************************
	// verdict and end of run
	task automatic summarize;
		if (exp_q.size() != 0 || ram_q.size() != 0)
			errors++;
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one comparison of expected against observed
	task automatic cmp(input logic [39:0] e, input logic [39:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	// wait for an edge with hready high, bounded
	task automatic wt;
		int t;
		t = 0;
		do begin
			@(posedge mclk_i);
			t++;
		end while (hready !== 1'b1 && t < 40);
		if (t >= 40) begin
			errors++;
			summarize;
		end
	endtask
	// one single ahb-lite transfer
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge mclk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wt;
		rd_q = hrdata;
		cmp(40'h0, {39'h0, hresp});
	endtask
	// read with a note of the expected masked value
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back({8'h0, e});
		bus(1'b0, a, 32'h0);
		rd_q = rd_q & m;
		-> rd_ev;
	endtask
	// read results, oldest note first
	initial begin
		forever begin
			@(rd_ev);
			cmp(exp_q.pop_front(), {8'h0, rd_q});
		end
	end
	// ram write monitor, oldest note first
	always @(posedge mclk_i) begin
		if (ram.wr === 1'b1) begin
			if (ram_q.size() == 0)
				cmp(40'h0, 40'h1);
			else begin
				re = ram_q.pop_front();
				cmp(re[39:0], {ram.wide, 3'h0, ram.row, ram.seg,
					ram.data[23:0]});
				cmp({36'h0, re[43:40]}, {36'h0, ram.page});
			end
		end
	end
	// random instruction bits
	task automatic rnd;
		for (int i = 0; i < 9; i++)
			d[i*32 +: 32] = $random(seed);
	endtask
	task automatic frame(input logic [7:0] a, input logic [8:0] n,
		input logic park);
		host.send({8'h0, d[271:0], a}, int'(n), park);
	endtask
	// status, settings and power outputs after a frame
	task automatic st(input logic [8:0] n, input lcdsr_res_e r);
		pn = n;
		pr = r;
		rd(OFS_STATUS, {20'h0, ms, r, n}, 32'hfff);
		cmp({7'h0, ec}, {7'h0, cfg});
		cmp({37'h0, ms & ~ec.fund_timing_source & ~ec.power_save,
			ec.booster_run & ~ec.power_save, ec.booster_run & ec.power_save},
			{37'h0, osc_run, b_on, disch});
	endtask
	task automatic method(input logic flip);
		rnd;
		d[POS_OC] = 1'b0;
		d[POS_DBC] = ~flip;
		d[POS_CONTRAST_ADJUST_RUN] = 1'b1;
		d[POS_BIAS_GENERATOR_RUN] = 1'b1;
		d[POS_SEGMENT_ORDER_FLIP] = flip;
		ec.fund_timing_source = d[POS_OC];
		ec.booster_run = d[POS_DBC];
		ec.contrast_adjust_run = d[POS_CONTRAST_ADJUST_RUN];
		ec.bias_generator_run = d[POS_BIAS_GENERATOR_RUN];
		ec.duty = d[POS_DT +: 4];
		ec.drive_mode = d[POS_DR];
		ec.wave_mode = d[POS_WVC];
		ec.common_flip = d[POS_CDIR];
		ec.segment_order_flip = d[POS_SEGMENT_ORDER_FLIP];
		ec.boost_freq = d[POS_DBF +: 3];
		ec.frame_freq = d[POS_FC +: 4];
		ms = 1'b1;
		frame(DA, 9'h028, 1'b0);
		st(9'h028, RES_OK);
	endtask
	task automatic short(input logic [3:0] code, input logic ps,
		input logic park);
		rnd;
		d[POS_CODE +: 4] = code;
		d[POS_BU] = ps;
		case (code)
			CODE_ONOFF: {ec.display_on, ec.show_mode, ec.power_save} =
				{d[POS_PNC], d[POS_SC +: 2], d[POS_BU]};
			CODE_LINE: ec.line_addr = d[POS_LINE +: 4];
			CODE_CONTRAST: ec.contrast = d[POS_CT +: 6];
			default: ;
		endcase
		frame(DA, 9'h018, park);
		st(9'h018, (code >= 4'h1 && code <= 4'h3) ? RES_OK : RES_LEN);
	endtask
	task automatic bulk(input logic wide, input logic [7:0] col,
		input logic [3:0] row);
		logic ok;
		rnd;
		ok = wide ? (col >= COL_MIN && col <= B16_COL_MAX && row == ROW_LOW)
			: (col >= COL_MIN && col <= B8_COL_MAX &&
			(row == ROW_LOW || row == ROW_HIGH));
		d[(wide ? B16_COL : B8_COL) +: 8] = col;
		d[B8_ROW +: 4] = wide ? d[B8_ROW +: 4] : row;
		if (ok)
			ram_q.push_back({wide ? d[B16_PAGE +: 4] : 4'h0,
				wide, 3'h0, wide ? ROW_LOW : row,
				ec.segment_order_flip ? SEG_LAST + 8'h01 - col : col,
				d[23:0]});
		frame(DA, wide ? 9'h118 : 9'h098, 1'b0);
		st(wide ? 9'h118 : 9'h098, ok ? RES_OK : RES_RANGE);
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		ec = CFG_RST;
		ms = 1'b0;
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd(OFS_CTRL, 32'h1, 32'hffffffff);
		rd(OFS_STATUS, 32'h0, 32'hffffffff);
		rd(8'h10, 32'h0, 32'hffffffff);
		rnd;
		frame(~DA, 9'h028, 1'b0);
		st(9'h028, RES_ADDR);
		// booster, contrast and bias all run: host settle wait is its own
		method(1'b0);
		frame(DA, 9'h029, 1'b1);
		st(9'h029, RES_LEN);
		// cut frame shorter than the address byte
		frame(DA, 9'h005, 1'b1);
		st(9'h005, RES_LEN);
		for (int c = 1; c < 5; c++)
			short(c[3:0], 1'b0, c[0]);
		// the receiver times nothing, so frames follow the waits at once
		short(CODE_ONOFF, 1'b1, 1'b0);
		short(CODE_ONOFF, 1'b0, 1'b1);
		bulk(1'b0, 8'hba, 4'h9);
		bulk(1'b0, 8'hbb, 4'h9);
		bulk(1'b0, 8'h01, 4'h5);
		bulk(1'b0, 8'h01, 4'h1);
		// booster off, contrast and bias only
		method(1'b1);
		bulk(1'b1, 8'hb9, 4'h1);
		bulk(1'b1, 8'hba, 4'h1);
		bulk(1'b1, 8'h00, 4'h1);
		bulk(1'b0, 8'h10, 4'h9);
		bus(1'b1, OFS_CTRL, 32'h0);
		frame(DA, 9'h018, 1'b0);
		st(pn, pr);
		bus(1'b1, OFS_CTRL, 32'h1);
		rd(OFS_CTRL, 32'h1, 32'hffffffff);
		hclr_n <= 1'b0;
		repeat (5) @(posedge mclk_i);
		cmp(40'h1, {39'h0, disch});
		hclr_n <= 1'b1;
		repeat (5) @(posedge mclk_i);
		ec = CFG_RST;
		ms = 1'b0;
		rd(OFS_STATUS, 32'h0, 32'h800);
		cmp({7'h0, ec}, {7'h0, cfg});
		// let the read checker take the last note first
		@(posedge mclk_i);
		summarize;
	end
endmodule

// >>> dv/lcdsr_host_model.sv
// lcdsr_host_model: host end of the serial link, sends whole frames.
// assumes: the bench calls send; between frames the link clock only steps to the next park level.
`timescale 1ns/1ns
module lcdsr_host_model (
	// serial link towards the receiver
	output logic shift_clock_o,
	output logic chip_enable_o,
	output logic serial_data_o
);
	// ****************************************************************
	// frame sender
	// ****************************************************************
	// idle levels at time zero
	initial begin
		shift_clock_o = 1'b0;
		chip_enable_o = 1'b1;
		serial_data_o = 1'b0;
		// one enable fall arms the receiver's bit count
		#1 chip_enable_o = 1'b0;
	end
	// address bits first, then instruction bits, 6 ns link clock
	task automatic send(input logic [287:0] bits, input int n,
		input logic park);
		shift_clock_o = park;
		#7 chip_enable_o = 1'b1;
		for (int k = 0; k < n; k++) begin
			#3 shift_clock_o = 1'b0;
			serial_data_o = bits[k];
			#3 shift_clock_o = 1'b1;
		end
		#3 shift_clock_o = park;
		#2 chip_enable_o = 1'b0;
		serial_data_o = ~serial_data_o; // line driven to the inverse of the last bit
		#150;
	endtask
endmodule
